//--- adcc_conv_seq.sv
`timescale 1ns/10ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_conv_seq (
    // clock, reset, freeze
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // link to the register side
    adcc_seq_if.seq sq
);
    import adcc_pkg::*;

    adcc_state_t state_r;
    logic [6:0] div_r;
    logic [3:0] tick_cnt_r;
    logic tick;
    logic done_r;
    adcc_code_t code_r;

    // terminal count of the divider for a select code, 2**sel - 1
    function automatic logic [6:0] div_mask(input adcc_clksel_t sel);
        div_mask = 7'((8'h01 << sel) - 8'h01);
    endfunction

    // converter clock enable; divider restarts with each conversion so timing is exact
    assign tick = (state_r != ADCC_IDLE) && (div_r == div_mask(sq.clk_sel));

    // divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r <= 7'h00;
        end else if (ce_i) begin
            if (sq.abort || sq.start || tick) begin
                div_r <= 7'h00;
            end else if (state_r != ADCC_IDLE) begin
                div_r <= div_r + 7'h01;
            end
        end
    end

    // sample then convert, sixteen converter clocks in all
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= ADCC_IDLE;
            tick_cnt_r <= 4'h0;
        end else if (ce_i) begin
            // start wins: the stored start bit still reads high in the start cycle
            if (sq.start) begin
                state_r <= ADCC_SAMPLE;
                tick_cnt_r <= 4'h0;
            end else if (sq.abort) begin
                state_r <= ADCC_IDLE;
                tick_cnt_r <= 4'h0;
            end else if (tick) begin
                tick_cnt_r <= tick_cnt_r + 4'h1;
                case (state_r)
                    ADCC_SAMPLE: begin
                        if (tick_cnt_r == 4'(`ADCC_SAMPLE_TICKS - 1)) begin
                            state_r <= ADCC_CONVERT;
                        end
                    end
                    ADCC_CONVERT: begin
                        if (tick_cnt_r == 4'(`ADCC_TOTAL_TICKS - 1)) begin
                            state_r <= ADCC_IDLE;
                        end
                    end
                    default: state_r <= ADCC_IDLE;
                endcase
            end
        end
    end

    // hold the input code at the end of sampling; it is an unsigned 12-bit value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_r <= 12'h000;
        end else if (ce_i && !sq.abort && tick && state_r == ADCC_SAMPLE &&
                     tick_cnt_r == 4'(`ADCC_SAMPLE_TICKS - 1)) begin
            code_r <= sq.ain_code;
        end
    end

    // one-cycle completion pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_r <= 1'b0;
        end else if (ce_i) begin
            done_r <= !sq.abort && tick && state_r == ADCC_CONVERT &&
                      tick_cnt_r == 4'(`ADCC_TOTAL_TICKS - 1);
        end
    end

    assign sq.done = done_r;
    assign sq.code = code_r;
    assign sq.sampling = (state_r == ADCC_SAMPLE);

    // checks
    a_sample_to_conv: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !sq.abort && !sq.start && tick && state_r == ADCC_SAMPLE && tick_cnt_r == 4'h3
        |=> state_r == ADCC_CONVERT)
        else $error("sampling did not end after four converter clocks");
    a_done_at_sixteen: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(done_r) |-> $past(tick_cnt_r) == 4'hf && $past(state_r) == ADCC_CONVERT)
        else $error("completion not after sixteen converter clocks");
    a_div_one_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        state_r != ADCC_IDLE && sq.clk_sel == 3'h0 |-> tick)
        else $error("divide by one does not tick every cycle");
    c_full_conv: cover property (@(posedge clk_i) disable iff (rst_i) $rose(done_r));
endmodule
`default_nettype wire

//--- adcc_defines.svh
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// register byte offsets
`define ADCC_OFS_CTRL_A 8'h00
`define ADCC_OFS_CTRL_B 8'h04
`define ADCC_OFS_RES_LO 8'h08
`define ADCC_OFS_RES_HI 8'h0c
`define ADCC_OFS_IRQ_STAT 8'h10
`define ADCC_OFS_IRQ_CLR 8'h14
`define ADCC_OFS_IRQ_EN 8'h18

// conv_control_a fields
`define ADCC_A_START 7
`define ADCC_A_BUSY 6
`define ADCC_A_PWR 5
`define ADCC_A_FMT 4
`define ADCC_A_CH_HI 3
`define ADCC_A_CH_LO 0

// conv_control_b fields
`define ADCC_B_REF_HI 4
`define ADCC_B_REF_LO 3
`define ADCC_B_CLK_HI 2
`define ADCC_B_CLK_LO 0

// interrupt status / clear / enable fields
`define ADCC_IRQ_CONV 0
`define ADCC_IRQ_GLOBAL 1

// reset values, and the reference code that selects vdd
`define ADCC_CTRL_A_RST 8'h00
`define ADCC_CTRL_B_RST 8'h00
`define ADCC_REF_VDD_CODE 2'h1

// timing in converter clocks, and the result code width in bits
`define ADCC_SAMPLE_TICKS 4
`define ADCC_TOTAL_TICKS 16
`define ADCC_CODE_W 12

`endif

//--- adcc_pkg.sv
package adcc_pkg;
    // gray-coded sequencer states along idle -> sample -> convert
    typedef enum logic [1:0] {
        ADCC_IDLE = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_CONVERT = 2'b11
    } adcc_state_t;

    typedef logic [11:0] adcc_code_t;
    typedef logic [2:0] adcc_clksel_t;
endpackage

//--- adcc_seq_if.sv
`timescale 1ns/10ps
`default_nettype none
interface adcc_seq_if;
    import adcc_pkg::*;
    logic start;
    logic abort;
    adcc_clksel_t clk_sel;
    adcc_code_t ain_code;
    logic done;
    adcc_code_t code;
    logic sampling;

    modport ctrl (output start, output abort, output clk_sel, output ain_code,
                  input done, input code, input sampling);
    modport seq (input start, input abort, input clk_sel, input ain_code,
                 output done, output code, output sampling);
endinterface
`default_nettype wire

//--- adcc_test.sv
`timescale 1ns/10ps
`default_nettype none
module adcc_test;
    import adcc_pkg::*;
    // design stimulus and observation
    logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack_o, power_en_o, ref_vdd_o, sampling_o, irq_o, irq_q;
    logic [3:0] channel_sel_o;
    adcc_code_t ain_code_i;
    logic [31:0] rdat, lfsr;
    int err_total, check_count, cyc_cnt, t_start, t_irq, run, samp_len;
    adcc_code_t code_q[$];

    adcc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ain_code_i(ain_code_i), .power_en_o(power_en_o), .ref_vdd_o(ref_vdd_o),
        .channel_sel_o(channel_sel_o), .sampling_o(sampling_o), .irq_o(irq_o));

    // free clock, 10 ns period
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // cycle count, hang guard, sampling length and interrupt edge time
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        irq_q <= irq_o;
        if (irq_o === 1'b1 && irq_q !== 1'b1) t_irq <= cyc_cnt;
        if (sampling_o === 1'b1) run <= run + 1;
        else if (run != 0) begin
            samp_len <= run;
            run <= 0;
        end
        if (cyc_cnt == 60000) begin
            err_total++;
            end_sim();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // classic single cycle; held until ack is sampled high at an edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                      input logic [3:0] sel, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, dat};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20) chk(wb_ack_o, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, 4'h1, d);
    endtask

    task automatic rd(input logic [7:0] adr);
        wb(1'b0, adr, 8'h00, 4'hf, rdat);
    endtask

    // one full conversion with the bench's own expectation of the result
    task automatic conv(input int sel, input int fmt, input int rsel, input int en,
                        input adcc_code_t code);
        adcc_code_t c;
        int n, lo, hi;
        ain_code_i <= code;
        code_q.push_back(code);
        wr(8'h04, 8'((rsel << 3) | sel));
        wr(8'h00, 8'(8'h20 | (fmt << 4)));
        wr(8'h14, 8'h01);
        wr(8'h18, 8'(en));
        chk(ref_vdd_o, 32'(rsel == 1));
        chk(power_en_o, 32'h1);
        chk(channel_sel_o, 32'h0);
        wr(8'h00, 8'(8'ha0 | (fmt << 4)));
        wr(8'h00, 8'(8'h20 | (fmt << 4)));
        t_start = cyc_cnt;
        rd(8'h00);
        chk(rdat[6], 32'h1);
        n = 0;
        // software polls the busy bit, whatever the interrupt setup
        do begin
            rd(8'h00);
            n++;
        end while (rdat[6] !== 1'b0 && n < 1000);
        chk(rdat[6], 32'h0);
        repeat (2) @(posedge clk_i);
        chk(samp_len, 32'(4 << sel));
        chk(irq_o, 32'(en == 3));
        if (en == 3) begin
            chk(32'((t_irq - t_start) >= (16 << sel)), 32'h1);
            chk(32'((t_irq - t_start) <= (16 << sel) + 3), 32'h1);
        end
        rd(8'h10);
        chk(rdat, 32'h1);
        c = code_q.pop_front();
        lo = (fmt == 1) ? (c & 12'h0ff) : ((c & 12'h00f) << 4);
        hi = (fmt == 1) ? (c >> 8) : (c >> 4);
        // low byte first, then high byte
        rd(8'h08);
        chk(rdat, 32'(lo));
        rd(8'h0c);
        chk(rdat, 32'(hi));
        wr(8'h14, 8'h01);
        rd(8'h10);
        chk(rdat, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 32'h0);
        $display("conversion test sel %0d done", sel);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // main sequence: reset values, conversions over every divider, aborts
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        ain_code_i = 12'h000;
        err_total = 0;
        check_count = 0;
        cyc_cnt = 0;
        run = 0;
        samp_len = 0;
        t_irq = 0;
        lfsr = 32'hcb71;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00);
        chk(rdat, 32'h0);
        rd(8'h04);
        chk(rdat, 32'h0);
        rd(8'h10);
        chk(rdat, 32'h0);
        rd(8'h1c);
        chk(rdat, 32'h0);
        chk(irq_o, 32'h0);
        wb(1'b1, 8'h04, 8'h1f, 4'h0, rdat);
        rd(8'h04);
        chk(rdat, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            conv(i, i % 2, i % 4, (i == 5) ? 1 : ((i % 3 != 0) ? 3 : 2),
                 (i == 7) ? 12'hfff : ((i == 6) ? 12'h000 : lfsr[11:0]));
        end
        // abort by start high, then by power down, on a long conversion
        wr(8'h04, 8'h03);
        wr(8'h00, 8'h25);
        // the pin copy lands one edge after the register
        @(posedge clk_i);
        chk(channel_sel_o, 32'h5);
        wr(8'h00, 8'ha0);
        wr(8'h00, 8'h20);
        rd(8'h00);
        chk(rdat[6], 32'h1);
        wr(8'h00, 8'ha0);
        rd(8'h00);
        chk(rdat[6], 32'h0);
        wr(8'h00, 8'h20);
        rd(8'h00);
        chk(rdat[6], 32'h1);
        // freeze for longer than the conversion; busy must survive it
        ce_i <= 1'b0;
        repeat (200) @(posedge clk_i);
        ce_i <= 1'b1;
        rd(8'h00);
        chk(rdat[6], 32'h1);
        wr(8'h00, 8'h00);
        rd(8'h00);
        chk(rdat[6], 32'h0);
        chk(power_en_o, 32'h0);
        repeat (140) @(posedge clk_i);
        rd(8'h10);
        chk(rdat, 32'h0);
        $display("abort test done");
        // a start pulse with the converter powered down does nothing
        wr(8'h00, 8'h80);
        wr(8'h00, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(sampling_o, 32'h0);
        rd(8'h00);
        chk(rdat[6], 32'h0);
        repeat (140) @(posedge clk_i);
        rd(8'h10);
        chk(rdat, 32'h0);
        $display("powered down start test done");
        end_sim();
    end
endmodule
`default_nettype wire

//--- adcc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "adcc_defines.svh"
module adcc_top (
    // clock, reset, freeze
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // digitised level of the selected analog input
    input wire adcc_pkg::adcc_code_t ain_code_i,
    // analog front end control
    output logic power_en_o,
    output logic ref_vdd_o,
    output logic [3:0] channel_sel_o,
    output logic sampling_o,
    // interrupt
    output logic irq_o
);
    import adcc_pkg::*;

    adcc_seq_if sq ();

    logic ack_r;
    logic [31:0] dat_r;
    logic start_r;
    logic power_r;
    logic format_r;
    logic [3:0] chan_r;
    logic [1:0] ref_r;
    adcc_clksel_t clk_sel_r;
    logic busy_r;
    logic flag_r;
    logic conv_en_r;
    logic glob_en_r;
    logic [7:0] res_lo_r;
    logic [7:0] res_hi_r;
    logic irq_r;
    logic power_out_r;
    logic ref_vdd_r;
    logic [3:0] chan_out_r;
    logic samp_r;

    logic req;
    logic wr;
    logic wr_a;
    logic start_go;
    logic abort;
    logic [7:0] rd_byte;

    // one wait state: ack the cycle after the request, drop it right after
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign wr_a = wr && wb_adr_i == `ADCC_OFS_CTRL_A;

    // falling edge of the start bit begins a conversion, but only when powered
    assign start_go = wr_a && start_r && !wb_dat_i[`ADCC_A_START] &&
                      wb_dat_i[`ADCC_A_PWR] && power_r;
    // start held high or power removed keeps the converter reset
    assign abort = start_r || !power_r;

    assign sq.start = ce_i && start_go;
    assign sq.abort = abort;
    assign sq.clk_sel = clk_sel_r;
    assign sq.ain_code = ain_code_i;

    adcc_conv_seq u_seq (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i (ce_i),
        .sq (sq)
    );

    // bus handshake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else if (ce_i) begin
            ack_r <= req;
        end
    end

    // read mux; unmapped offsets read zero and their writes are dropped
    always_comb begin
        case (wb_adr_i)
            `ADCC_OFS_CTRL_A: rd_byte = {start_r, busy_r, power_r, format_r, chan_r};
            `ADCC_OFS_CTRL_B: rd_byte = {3'h0, ref_r, clk_sel_r};
            `ADCC_OFS_RES_LO: rd_byte = res_lo_r;
            `ADCC_OFS_RES_HI: rd_byte = res_hi_r;
            `ADCC_OFS_IRQ_STAT: rd_byte = {7'h00, flag_r};
            `ADCC_OFS_IRQ_EN: rd_byte = {6'h00, glob_en_r, conv_en_r};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (ce_i && req) begin
            dat_r <= {24'h00_0000, rd_byte};
        end
    end

    // conv_control_a: 20 gives power on, right format off, channel zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {start_r, power_r, format_r, chan_r} <= 7'h00;
        end else if (ce_i && wr_a) begin
            start_r <= wb_dat_i[`ADCC_A_START];
            power_r <= wb_dat_i[`ADCC_A_PWR];
            format_r <= wb_dat_i[`ADCC_A_FMT];
            chan_r <= wb_dat_i[`ADCC_A_CH_HI:`ADCC_A_CH_LO];
        end
    end

    // conv_control_b: reference and converter clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_r <= 2'h0;
            clk_sel_r <= 3'h0;
        end else if (ce_i && wr && wb_adr_i == `ADCC_OFS_CTRL_B) begin
            ref_r <= wb_dat_i[`ADCC_B_REF_HI:`ADCC_B_REF_LO];
            clk_sel_r <= wb_dat_i[`ADCC_B_CLK_HI:`ADCC_B_CLK_LO];
        end
    end

    // interrupt enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_en_r <= 1'b0;
            glob_en_r <= 1'b0;
        end else if (ce_i && wr && wb_adr_i == `ADCC_OFS_IRQ_EN) begin
            conv_en_r <= wb_dat_i[`ADCC_IRQ_CONV];
            glob_en_r <= wb_dat_i[`ADCC_IRQ_GLOBAL];
        end
    end

    // busy: set on accepted start, cleared by completion or converter reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
        end else if (ce_i) begin
            if (start_go) begin
                busy_r <= 1'b1;
            end else if (sq.done || abort) begin
                busy_r <= 1'b0;
            end
        end
    end

    // sticky done flag; a completion in the clearing cycle still sets it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= 1'b0;
        end else if (ce_i) begin
            if (sq.done) begin
                flag_r <= 1'b1;
            end else if (wr && wb_adr_i == `ADCC_OFS_IRQ_CLR &&
                         wb_dat_i[`ADCC_IRQ_CONV]) begin
                flag_r <= 1'b0;
            end
        end
    end

    // result split; format 0 left-justifies, format 1 right-justifies
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_lo_r <= 8'h00;
            res_hi_r <= 8'h00;
        end else if (ce_i && sq.done) begin
            if (format_r) begin
                res_hi_r <= {4'h0, sq.code[11:8]};
                res_lo_r <= sq.code[7:0];
            end else begin
                res_hi_r <= sq.code[11:4];
                res_lo_r <= {sq.code[3:0], 4'h0};
            end
        end
    end

    // registered outputs; the reference picks vdd only for code 01
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r <= 1'b0;
            power_out_r <= 1'b0;
            ref_vdd_r <= 1'b0;
            chan_out_r <= 4'h0;
            samp_r <= 1'b0;
        end else if (ce_i) begin
            irq_r <= flag_r && conv_en_r && glob_en_r;
            power_out_r <= power_r;
            ref_vdd_r <= (ref_r == `ADCC_REF_VDD_CODE);
            chan_out_r <= chan_r;
            samp_r <= sq.sampling;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign irq_o = irq_r;
    assign power_en_o = power_out_r;
    assign ref_vdd_o = ref_vdd_r;
    assign channel_sel_o = chan_out_r;
    assign sampling_o = samp_r;

    // checks
    a_start_sets_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && start_go |=> busy_r)
        else $error("busy not set after start");
    a_done_clears_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && sq.done |=> !busy_r && flag_r)
        else $error("completion did not drop busy and raise flag");
    a_off_no_start: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !power_r && !busy_r |=> !busy_r)
        else $error("busy raised while powered down");
    a_power_aborts: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !power_r |=> !busy_r && !sq.done)
        else $error("conversion continued while powered down");
    a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> irq_o == ($past(flag_r) && $past(conv_en_r) && $past(glob_en_r)))
        else $error("interrupt output does not follow flag and both enables");
    a_ref_select: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ref_r != 2'h1 |=> !ref_vdd_o)
        else $error("supply reference chosen for a code other than 01");
    a_fmt_right: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && sq.done && format_r |=> res_hi_r[7:4] == 4'h0 &&
        res_lo_r == $past(sq.code[7:0]))
        else $error("right-justified result split wrong");
    a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && sq.done && wr && wb_adr_i == 8'h14 |=> flag_r)
        else $error("completion lost against clear");
    a_busy_span: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && start_go && clk_sel_r == 3'h0 ##1 (ce_i && !wr)[*8] |-> busy_r)
        else $error("busy dropped before the conversion could end");
    a_abort_clears_busy: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && abort && !start_go |=> !busy_r)
        else $error("busy survived a converter reset");
    a_irq_low_off: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !glob_en_r |=> !irq_o)
        else $error("interrupt raised with the global enable low");
    a_ref_vdd_on: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ref_r == `ADCC_REF_VDD_CODE |=> ref_vdd_o)
        else $error("supply reference not chosen for code 01");

    // flag and result handling
    a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !sq.done && wr && wb_adr_i == `ADCC_OFS_IRQ_CLR &&
        wb_dat_i[`ADCC_IRQ_CONV] |=> !flag_r)
        else $error("flag not cleared by a write of one");
    a_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && flag_r && !(wr && wb_adr_i == `ADCC_OFS_IRQ_CLR) |=> flag_r)
        else $error("flag dropped without a clear");
    a_fmt_left: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && sq.done && !format_r |=> res_lo_r[3:0] == 4'h0 &&
        res_hi_r == $past(sq.code[11:4]))
        else $error("left-justified result split wrong");

    // bus handshake, dropped writes and freeze
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ack_r |=> !ack_r)
        else $error("acknowledge held longer than one cycle");
    a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req |=> ack_r)
        else $error("request not acknowledged in the next cycle");
    a_no_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !(wb_cyc_i && wb_stb_i) |=> !ack_r)
        else $error("acknowledge without a request");
    a_sel_drop_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && req && wb_we_i && !wb_sel_i[0] |=> $stable(ref_r) &&
        $stable(clk_sel_r) && $stable(power_r) && $stable(conv_en_r))
        else $error("write with the low byte lane off changed a register");
    a_freeze_state: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(busy_r) && $stable(flag_r) && $stable(ack_r))
        else $error("state moved while the clock enable was low");

    // registered copies on the front end pins
    a_power_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> power_en_o == $past(power_r))
        else $error("power output does not follow the enable bit");
    a_chan_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> channel_sel_o == $past(chan_r))
        else $error("channel output does not follow the channel field");
    a_samp_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i |=> sampling_o == $past(sq.sampling))
        else $error("sampling output does not follow the sequencer");
    c_fmt_left: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && sq.done && !format_r);
    c_start: cover property (@(posedge clk_i) disable iff (rst_i) ce_i && start_go);
    c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
    c_abort: cover property (@(posedge clk_i) disable iff (rst_i) busy_r && abort && ce_i);
endmodule
`default_nettype wire
